/* host_l2_ctl.sv */
`timescale 1ns/1ns
// Processor bus decode and external second-level cache strobes
module host_l2_ctl #(
  parameter int unsigned RESET_HOLD = l2ctl_pkg::RESET_HOLD_CYC,
  parameter int unsigned TAG_BITS = l2ctl_pkg::TAG_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic power_good_in,
  output logic cpu_reset,
  // Configuration
  input wire logic sync_cache,
  input wire logic double_bank,
  input wire logic combined_tag_dirty,
  input wire logic tag7_mode,
  input wire logic row_strobe5_sel,
  input wire logic write_back_policy,
  // Local decode inputs from the memory side
  input wire logic local_mem_hit,
  input wire logic cacheable_region,
  input wire logic mem_data_ready,
  // Processor bus
  input wire logic cycle_strobe_n,
  input wire logic mem_io,
  input wire logic data_ctl,
  input wire logic wr_rd_in,
  output logic wr_rd_out,
  output logic wr_rd_oe,
  input wire logic [31:3] host_addr_in,
  output logic [31:5] host_addr_out,
  output logic host_addr_oe,
  input wire logic [7:0] byte_lane_enables_n_in,
  output logic [7:0] byte_lane_enables_n_out,
  output logic byte_lane_enables_oe,
  output logic burst_ready_n,
  output logic next_addr_req_n,
  output logic cacheable_or_local_mem_n,
  output logic snoop_strobe_or_policy,
  output logic [7:0] return_lanes,
  output logic [7:0] special_type,
  output logic special_valid,
  // Forwarding toward PCI
  output logic pci_fwd,
  output logic pci_inta,
  input wire logic pci_done,
  // Bus master / inquire
  input wire logic master_active,
  input wire logic snoop_req,
  input wire logic [31:5] snoop_addr,
  input wire logic [7:0] master_be_n,
  // Cache SRAM strobes
  output logic even_bank_oe_n,
  output logic odd_bank_oe_n,
  output logic even_we_or_bank_sel0_n,
  output logic odd_we_or_bank_sel1_n,
  output logic [7:0] sram_sel_or_byte_we_n,
  output logic even_a4_or_ctrl_strobe,
  output logic odd_a4_or_a3_or_advance,
  output logic cache_addr_latch_en,
  output logic [31:3] latched_addr,
  // Tag and dirty RAM
  input wire logic [7:0] tag_in,
  output logic [7:0] tag_out,
  output logic tag_oe,
  output logic tag_store_strobe_n,
  input wire logic line_modified_in,
  output logic line_modified_out,
  output logic line_modified_oe,
  output logic modified_we_or_row_strobe5_n,
  input wire logic row_strobe5_n
);
  initial begin
    if (TAG_BITS != 8) $error("TAG_BITS must be 8");
  end

  l2ctl_pkg::host_st_t st_r, st_nxt;
  logic [31:3] addr_r;
  logic [2:0] def_r;
  logic [7:0] be_r;
  logic hit_r, dirty_r, na_done_r;
  logic [1:0] beat_r;
  logic [31:5] snp_addr_r;

  // Cycle definition decode, used at start and in the data phase
  function automatic logic is_special(input logic [2:0] d);
    return d == l2ctl_pkg::CYC_SPECIAL;
  endfunction : is_special
  function automatic logic is_fwd(input logic [2:0] d, input logic loc);
    return (d == l2ctl_pkg::CYC_INTA) | ~d[2] | ~loc;
  endfunction : is_fwd

  wire start = ~cycle_strobe_n & ~master_active;
  wire [2:0] def_in = {mem_io, data_ctl, wr_rd_in};
  wire is_write = def_r[0];
  wire is_read = ~def_r[0];
  wire cacheable = def_r[2] & cacheable_region;
  wire [TAG_BITS-1:0] cur_tag = addr_r[31:24];
  // Seven-bit tag gives bit 0 to the dirty flag
  wire [7:0] tag_mask = (combined_tag_dirty & tag7_mode) ? 8'hFE : 8'hFF;
  wire tag_match = ((tag_in ^ cur_tag) & tag_mask) == 8'h00;
  wire dirty_now = (combined_tag_dirty & tag7_mode) ?
    tag_in[l2ctl_pkg::DIRTY_BIT_POS] : line_modified_in;
  wire in_data = st_r == l2ctl_pkg::ST_DATA;
  wire in_snoop = st_r == l2ctl_pkg::ST_SNOOP;
  wire in_tagw = st_r == l2ctl_pkg::ST_TAGW;
  wire data_ok = hit_r | mem_data_ready;

  // Next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      l2ctl_pkg::ST_IDLE: begin
        if (snoop_req & master_active) st_nxt = l2ctl_pkg::ST_SNOOP;
        else if (start) begin
          if (is_special(def_in)) st_nxt = l2ctl_pkg::ST_DATA;
          else if (is_fwd(def_in, local_mem_hit)) st_nxt = l2ctl_pkg::ST_FWD;
          else st_nxt = l2ctl_pkg::ST_LOOK;
        end
      end
      l2ctl_pkg::ST_LOOK: st_nxt = l2ctl_pkg::ST_DATA;
      l2ctl_pkg::ST_DATA: begin
        if (is_special(def_r) | (data_ok & (beat_r == 2'h3 | ~cacheable)))
          st_nxt = (~hit_r & is_read & cacheable) ?
            l2ctl_pkg::ST_TAGW : l2ctl_pkg::ST_IDLE;
      end
      l2ctl_pkg::ST_TAGW: st_nxt = l2ctl_pkg::ST_IDLE;
      l2ctl_pkg::ST_SNOOP: st_nxt = l2ctl_pkg::ST_IDLE;
      l2ctl_pkg::ST_FWD: if (pci_done) st_nxt = l2ctl_pkg::ST_IDLE;
      default: st_nxt = l2ctl_pkg::ST_IDLE;
    endcase
  end

  // State and captured cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= l2ctl_pkg::ST_IDLE;
      addr_r <= 29'h0;
      def_r <= 3'h0;
      be_r <= 8'hFF;
      snp_addr_r <= 27'h0;
    end else begin
      st_r <= st_nxt;
      if (st_r == l2ctl_pkg::ST_IDLE & start) begin
        addr_r <= host_addr_in;
        def_r <= def_in;
        be_r <= byte_lane_enables_n_in;
      end
      if (st_r == l2ctl_pkg::ST_IDLE & snoop_req) snp_addr_r <= snoop_addr;
    end
  end

  // Lookup result, beat counter, next-address bookkeeping
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_r <= 1'b0;
      dirty_r <= 1'b0;
      beat_r <= 2'h0;
      na_done_r <= 1'b0;
    end else begin
      if (st_r == l2ctl_pkg::ST_LOOK) begin
        hit_r <= tag_match;
        dirty_r <= dirty_now;
        beat_r <= 2'h0;
        na_done_r <= 1'b0;
      end
      if (in_data & data_ok) beat_r <= beat_r + 2'h1;
      if (in_data) na_done_r <= 1'b1;
    end
  end

  // Processor-facing handshakes
  assign burst_ready_n = ~(in_data & (data_ok | is_special(def_r)));
  // One pulse, first data clock of a local cycle
  assign next_addr_req_n = ~(in_data & ~na_done_r & ~is_special(def_r));
  assign cacheable_or_local_mem_n = master_active ? ~local_mem_hit :
    ~cacheable;
  // Active-low snoop strobe in inquire, policy level otherwise
  assign snoop_strobe_or_policy = in_snoop ? 1'b0 : write_back_policy;
  assign return_lanes = (is_read & cacheable) ? 8'hFF : ~be_r;
  assign special_valid = in_data & is_special(def_r);
  assign special_type = ~be_r;
  assign pci_fwd = st_r == l2ctl_pkg::ST_FWD;
  assign pci_inta = pci_fwd & (def_r == l2ctl_pkg::CYC_INTA);

  // Inquire drive of address and write/read pin
  assign host_addr_oe = in_snoop;
  assign host_addr_out = snp_addr_r;
  assign wr_rd_oe = in_snoop;
  assign wr_rd_out = combined_tag_dirty ? 1'b1 : dirty_now;
  assign byte_lane_enables_oe = master_active;
  assign byte_lane_enables_n_out = master_be_n;

  // Cache SRAM strobes depend on async/sync build
  wire rd_hit = in_data & hit_r & is_read;
  wire wr_hit = in_data & hit_r & is_write;
  wire fill = in_data & ~hit_r & is_read & cacheable & mem_data_ready;
  wire odd_sel = double_bank & beat_r[0];
  assign even_bank_oe_n = ~(rd_hit & ~odd_sel);
  assign odd_bank_oe_n = ~(rd_hit & odd_sel);
  assign even_we_or_bank_sel0_n = sync_cache ? ~(in_data & hit_r) :
    ~((wr_hit | fill) & ~odd_sel);
  assign odd_we_or_bank_sel1_n = sync_cache ? 1'b1 :
    ~((wr_hit | fill) & odd_sel);
  assign sram_sel_or_byte_we_n = sync_cache ?
    ((wr_hit | fill) ? be_r : 8'hFF) :
    ((in_data & (hit_r | fill)) ? 8'h00 : 8'hFF);
  wire [2:0] a43 = {1'b0, addr_r[4:3]} + {1'b0, beat_r};
  assign even_a4_or_ctrl_strobe = sync_cache ?
    ~(st_r == l2ctl_pkg::ST_LOOK) : a43[1];
  assign odd_a4_or_a3_or_advance = sync_cache ? ~(in_data & data_ok) :
    (double_bank ? a43[1] : a43[0]);
  // Latch is transparent while the processor starts a cycle
  assign cache_addr_latch_en = start & (st_r == l2ctl_pkg::ST_IDLE);
  assign latched_addr = addr_r;

  // Tag store on read miss; dirty bit written alongside in combined mode
  assign tag_store_strobe_n = ~in_tagw;
  assign tag_oe = in_tagw;
  assign tag_out = (combined_tag_dirty & tag7_mode) ?
    {cur_tag[7:1], 1'b0} : cur_tag;
  assign line_modified_oe = in_tagw & combined_tag_dirty & ~tag7_mode;
  assign line_modified_out = 1'b0;
  assign modified_we_or_row_strobe5_n = row_strobe5_sel ? row_strobe5_n :
    ~(wr_hit & ~combined_tag_dirty);

  reset_stretch #(
    .HOLD_CYC(RESET_HOLD)
  ) u_rst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .power_good_in(power_good_in),
    .cpu_reset(cpu_reset)
  );
endmodule : host_l2_ctl

/* l2ctl_pkg.sv */
package l2ctl_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned RESET_HOLD_US = 1000;
  localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_US * (CLK_HZ / 1000000));
  // Special-cycle code on memory/io, data/control, write/read
  localparam logic [2:0] CYC_SPECIAL = 3'h1;
  localparam logic [2:0] CYC_INTA = 3'h0;
  localparam int unsigned TAG_W = 8;
  localparam int unsigned DIRTY_BIT_POS = 0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOOK = 3'h1,
    ST_DATA = 3'h3,
    ST_TAGW = 3'h2,
    ST_SNOOP = 3'h6,
    ST_FWD = 3'h7
  } host_st_t;
endpackage : l2ctl_pkg

/* reset_stretch.sv */
`timescale 1ns/1ns
// Stretches processor reset after a rising power-good edge
module reset_stretch #(
  parameter int unsigned HOLD_CYC = l2ctl_pkg::RESET_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic power_good_in,
  output logic cpu_reset
);
  initial begin
    if (HOLD_CYC < 1) $error("HOLD_CYC must be at least 1");
  end
  logic [2:0] pg_sync_r;
  logic pg_prev_r;
  logic [31:0] cnt_r;
  wire pg_level = pg_sync_r[2];
  wire pg_rise = pg_sync_r[1] & pg_sync_r[2] & ~pg_prev_r;
  // Three-stage sync; previous level updates when the last two stages agree
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pg_sync_r <= 3'h0;
      pg_prev_r <= 1'b0;
    end else begin
      pg_sync_r <= {pg_sync_r[1:0], power_good_in};
      if (pg_sync_r[1] == pg_sync_r[2]) pg_prev_r <= pg_level;
    end
  end
  // Reset stays on while power is bad and for the hold after it rises
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 32'h0;
      cpu_reset <= 1'b1;
    end else if (pg_rise) begin
      cnt_r <= HOLD_CYC;
      cpu_reset <= 1'b1;
    end else if (cnt_r != 32'h0) begin
      cnt_r <= cnt_r - 32'h1;
      cpu_reset <= 1'b1;
    end else begin
      cpu_reset <= ~pg_prev_r;
    end
  end
endmodule : reset_stretch

/* host_l2_ctl_assertions.sv */
`timescale 1ns/1ns
// Port-level checks on reset, bus answers and cache strobes
module host_l2_ctl_assertions #(
  parameter int unsigned RESET_HOLD = l2ctl_pkg::RESET_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic power_good_in,
  input wire logic cpu_reset,
  input wire logic combined_tag_dirty,
  input wire logic sync_cache,
  input wire logic row_strobe5_sel,
  input wire logic write_back_policy,
  input wire logic wr_rd_in,
  input wire logic wr_rd_out,
  input wire logic wr_rd_oe,
  input wire logic host_addr_oe,
  input wire logic burst_ready_n,
  input wire logic next_addr_req_n,
  input wire logic cacheable_or_local_mem_n,
  input wire logic snoop_strobe_or_policy,
  input wire logic [7:0] return_lanes,
  input wire logic pci_fwd,
  input wire logic pci_done,
  input wire logic even_we_or_bank_sel0_n,
  input wire logic odd_we_or_bank_sel1_n,
  input wire logic tag_oe,
  input wire logic tag_store_strobe_n,
  input wire logic modified_we_or_row_strobe5_n
);
  logic [15:0] hi_cnt_r;
  // Reset time since power became good, saturating
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) hi_cnt_r <= 16'h0000;
    else if (!cpu_reset || !power_good_in) hi_cnt_r <= 16'h0000;
    else if (hi_cnt_r != 16'hFFFF) hi_cnt_r <= hi_cnt_r + 16'h0001;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_reset_hold;
    $fell(cpu_reset) |-> hi_cnt_r >= RESET_HOLD;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("processor reset released too early");
  property p_addr_drive;
    host_addr_oe |-> wr_rd_oe;
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("address driven outside inquire");
  property p_no_dirty_out;
    wr_rd_oe && combined_tag_dirty |-> wr_rd_out;
  endproperty
  a_no_dirty_out: assert property (p_no_dirty_out)
    else $error("dirty shown on write/read pin in combined mode");
  property p_next_addr_once;
    !next_addr_req_n |=> next_addr_req_n;
  endproperty
  a_next_addr_once: assert property (p_next_addr_once)
    else $error("next address request longer than one clock");
  property p_all_lanes;
    !burst_ready_n && !cacheable_or_local_mem_n && !wr_rd_in
      |-> return_lanes == 8'hFF;
  endproperty
  a_all_lanes: assert property (p_all_lanes)
    else $error("cacheable read does not return all lanes");
  property p_policy;
    !wr_rd_oe |-> snoop_strobe_or_policy == write_back_policy;
  endproperty
  a_policy: assert property (p_policy)
    else $error("policy pin wrong outside inquire");
  property p_one_bank;
    sync_cache |-> even_we_or_bank_sel0_n || odd_we_or_bank_sel1_n;
  endproperty
  a_one_bank: assert property (p_one_bank)
    else $error("both synchronous banks selected");
  property p_tag_drive;
    tag_oe |-> !tag_store_strobe_n;
  endproperty
  a_tag_drive: assert property (p_tag_drive)
    else $error("tag lines driven without tag strobe");
  property p_dirty_we;
    !modified_we_or_row_strobe5_n && !row_strobe5_sel
      |-> !combined_tag_dirty;
  endproperty
  a_dirty_we: assert property (p_dirty_we)
    else $error("dirty write enable used in combined mode");
  property p_fwd_hold;
    pci_fwd && !pci_done |=> pci_fwd;
  endproperty
  a_fwd_hold: assert property (p_fwd_hold)
    else $error("forward dropped before completion");
endmodule : host_l2_ctl_assertions

bind host_l2_ctl host_l2_ctl_assertions #(.RESET_HOLD(RESET_HOLD)) chk_i (
  .mclk, .sys_rst, .power_good_in, .cpu_reset, .combined_tag_dirty, .sync_cache,
  .row_strobe5_sel, .write_back_policy, .wr_rd_in, .wr_rd_out, .wr_rd_oe,
  .host_addr_oe, .burst_ready_n, .next_addr_req_n, .cacheable_or_local_mem_n,
  .snoop_strobe_or_policy, .return_lanes, .pci_fwd, .pci_done,
  .even_we_or_bank_sel0_n, .odd_we_or_bank_sel1_n, .tag_oe,
  .tag_store_strobe_n, .modified_we_or_row_strobe5_n
);

/* tag_ram_model.sv */
`timescale 1ns/1ns
// One-entry tag and dirty RAM; enough for a miss then a hit
module tag_ram_model (
  input wire logic mclk,
  input wire logic tag_oe,
  input wire logic [7:0] tag_out,
  input wire logic tag_store_strobe_n,
  input wire logic line_modified_oe,
  input wire logic line_modified_out,
  input wire logic modified_we_or_row_strobe5_n,
  output logic [7:0] tag_in,
  output logic line_modified_in
);
  logic [7:0] tag_r = 8'h00;
  logic dirty_r = 1'b0;
  // Store on the write strobes
  always @(posedge mclk) begin
    if (!tag_store_strobe_n) tag_r <= tag_out;
    if (!modified_we_or_row_strobe5_n) dirty_r <= 1'b1;
  end
  // Wire level from both drivers
  assign tag_in = tag_oe ? tag_out : tag_r;
  assign line_modified_in = line_modified_oe ? line_modified_out : dirty_r;
endmodule : tag_ram_model

/* tb_host_l2_ctl.sv */
`timescale 1ns/1ns
// Directed scenarios for reset, processor cycles and inquire
module tb_host_l2_ctl;
  localparam int unsigned HOLD = 20;
  localparam logic [31:3] LINE = {8'hA5, 21'h000010};
  logic mclk = 1'b0, sys_rst = 1'b1, power_good_in = 1'b0;
  logic sync_cache = 1'b0, double_bank = 1'b0, combined_tag_dirty = 1'b0;
  logic tag7_mode = 1'b0, row_strobe5_sel = 1'b0, write_back_policy = 1'b1;
  logic local_mem_hit = 1'b1, cacheable_region = 1'b1, mem_data_ready = 1'b1;
  logic cycle_strobe_n = 1'b1, mem_io = 1'b1, data_ctl = 1'b1, wr_rd_in = 1'b0;
  logic pci_done = 1'b0, master_active = 1'b0, snoop_req = 1'b0;
  logic [31:3] host_addr_in = 29'h0;
  logic [31:5] snoop_addr = 27'h2ABCDEF;
  logic [7:0] byte_lane_enables_n_in = 8'hFF, master_be_n = 8'h3C;
  logic [7:0] tag_in, tag_out, return_lanes, byte_lane_enables_n_out;
  logic [31:5] host_addr_out;
  logic cpu_reset, wr_rd_out, wr_rd_oe, host_addr_oe, byte_lane_enables_oe;
  logic burst_ready_n, next_addr_req_n, cacheable_or_local_mem_n;
  logic snoop_strobe_or_policy, special_valid, pci_fwd, pci_inta;
  logic even_bank_oe_n, odd_bank_oe_n, even_we_or_bank_sel0_n;
  logic odd_we_or_bank_sel1_n, tag_oe, tag_store_strobe_n, line_modified_in;
  logic line_modified_out, line_modified_oe, modified_we_or_row_strobe5_n;
  int fails = 0, num_checks = 0, cyc = 0;
  int ev [0:11];
  host_l2_ctl #(.RESET_HOLD(HOLD)) host_l2_ctl_i (.mclk, .sys_rst,
    .power_good_in, .cpu_reset, .sync_cache, .double_bank, .combined_tag_dirty,
    .tag7_mode, .row_strobe5_sel, .write_back_policy, .local_mem_hit,
    .cacheable_region, .mem_data_ready, .cycle_strobe_n, .mem_io, .data_ctl,
    .wr_rd_in, .wr_rd_out, .wr_rd_oe, .host_addr_in, .host_addr_out,
    .host_addr_oe, .byte_lane_enables_n_in, .byte_lane_enables_n_out,
    .byte_lane_enables_oe, .burst_ready_n, .next_addr_req_n,
    .cacheable_or_local_mem_n, .snoop_strobe_or_policy, .return_lanes,
    .special_type(), .special_valid, .pci_fwd, .pci_inta, .pci_done,
    .master_active, .snoop_req, .snoop_addr, .master_be_n, .even_bank_oe_n,
    .odd_bank_oe_n, .even_we_or_bank_sel0_n, .odd_we_or_bank_sel1_n,
    .sram_sel_or_byte_we_n(), .even_a4_or_ctrl_strobe(),
    .odd_a4_or_a3_or_advance(), .cache_addr_latch_en(), .latched_addr(),
    .tag_in, .tag_out, .tag_oe, .tag_store_strobe_n, .line_modified_in,
    .line_modified_out, .line_modified_oe, .modified_we_or_row_strobe5_n,
    .row_strobe5_n(1'b1));
  tag_ram_model tag_ram_model_i (.mclk, .tag_oe, .tag_out,
    .tag_store_strobe_n, .line_modified_oe, .line_modified_out,
    .modified_we_or_row_strobe5_n, .tag_in, .line_modified_in);
  initial begin
    forever #50 mclk = ~mclk;
  end
  task summarize;
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask : chk
  // One cycle or inquire, then 20 clocks of event counting
  task run(input logic [31:3] a, input logic [2:0] def, input logic snp);
    ev = '{default: 0};
    @(negedge mclk);
    {mem_io, data_ctl, wr_rd_in} = def;
    host_addr_in = a;
    byte_lane_enables_n_in = 8'hFB;
    master_active = snp;
    snoop_req = snp;
    cycle_strobe_n = snp;
    @(negedge mclk);
    cycle_strobe_n = 1'b1;
    snoop_req = 1'b0;
    repeat (20) begin
      ev[0] += !burst_ready_n;
      ev[1] += !next_addr_req_n;
      ev[2] += !tag_store_strobe_n;
      ev[3] += !modified_we_or_row_strobe5_n;
      ev[4] += pci_fwd;
      ev[5] += pci_inta;
      ev[6] += special_valid;
      ev[7] += host_addr_oe && host_addr_out === snoop_addr;
      ev[8] += !burst_ready_n && return_lanes === 8'hFF;
      ev[9] += !snoop_strobe_or_policy;
      ev[10] += !even_bank_oe_n || !odd_bank_oe_n;
      ev[11] += byte_lane_enables_oe && byte_lane_enables_n_out === 8'h3C;
      pci_done = pci_fwd;
      @(negedge mclk);
    end
    master_active = 1'b0;
  endtask : run
  task t_reset;
    @(negedge mclk);
    power_good_in = 1'b1;
    repeat (HOLD) @(negedge mclk);
    chk(cpu_reset, 1);
    repeat (8) @(negedge mclk);
    chk(cpu_reset, 0);
  endtask : t_reset
  // Miss, hit, write hit, then the pin given to the row strobe
  task t_memory;
    run(LINE, 3'h6, 1'b0);
    chk(ev[0], 4);
    chk(ev[1], 1);
    chk(ev[2], 1);
    chk(ev[8], 4);
    run(LINE, 3'h6, 1'b0);
    chk(ev[2], 0);
    chk(ev[10] > 0, 1);
    run(LINE, 3'h7, 1'b0);
    chk(ev[3], 4);
    row_strobe5_sel = 1'b1;
    run(LINE, 3'h7, 1'b0);
    chk(ev[3], 0);
  endtask : t_memory
  task t_other;
    run(LINE, 3'h1, 1'b0);
    chk(ev[0], 1);
    chk(ev[6] > 0, 1);
    run(LINE, 3'h2, 1'b0);
    chk(ev[4] > 0, 1);
    run(LINE, 3'h0, 1'b0);
    chk(ev[5] > 0, 1);
    local_mem_hit = 1'b0;
    run(LINE, 3'h6, 1'b0);
    chk(ev[4] > 0, 1);
  endtask : t_other
  // Inquire with separate, then combined, dirty storage
  task t_snoop;
    for (int m = 0; m < 2; m++) begin
      combined_tag_dirty = m[0];
      run(LINE, 3'h6, 1'b1);
      chk(ev[7] > 0, 1);
      chk(ev[9], 1);
      chk(ev[11] > 0, 1);
    end
  endtask : t_snoop
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_memory();
    t_other();
    t_snoop();
    summarize();
  end
endmodule : tb_host_l2_ctl
